// file: inc/bax_pkg.sv
// Package for the byte ALU: opcodes, flag layout, request and result types
package bax_pkg;

    // Operand and address widths
    localparam int unsigned BAX_DATA_W   = 8;
    localparam int unsigned BAX_ADDR_W   = 7;
    localparam int unsigned BAX_NIB_W    = 4;
    // Highest register address an operation may name
    localparam logic [6:0]  BAX_ADDR_MAX = 7'h7F;

    // Destination selector encodings
    localparam logic BAX_DEST_ACC = 1'b0;
    localparam logic BAX_DEST_REG = 1'b1;

    // Reset values
    localparam logic [7:0] BAX_ACC_RST  = 8'h00;
    localparam logic [2:0] BAX_FLAG_RST = 3'h0;

    // Operation codes
    typedef enum logic [1:0] {
        register_minus_accumulator_op = 2'h0,
        literal_exclusive_or_op       = 2'h1,
        register_exclusive_or_op      = 2'h2,
        nibble_exchange_op            = 2'h3
    } bax_op_t;

    // Status flags
    typedef struct packed {
        logic zero_flag;
        logic half_borrow_flag;
        logic borrow_n_flag;
    } bax_flags_t;

    // One operation request
    typedef struct packed {
        bax_op_t    op;
        logic       dest_reg;
        logic [6:0] addr;
        logic [7:0] operand;
        logic [7:0] literal;
    } bax_req_t;

    // Write-back to the register file
    typedef struct packed {
        logic       wr_en;
        logic [6:0] addr;
        logic [7:0] data;
    } bax_wb_t;

endpackage : bax_pkg

// file: src/bax_alu.sv
// Byte ALU: subtract, exclusive-OR and nibble exchange with flag update
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE_01 - Register minus accumulator, destination selectable
// RULE_02 - Literal XOR accumulator, result into accumulator
// RULE_03 - Accumulator XOR addressed register operand
// RULE_04 - Register XOR: selector one writes register
// RULE_05 - Nibble exchange swaps halves, flags untouched
// RULE_06 - Nibble exchange: selector zero writes accumulator
// RULE_07 - Borrow, half-borrow and zero flag updates
module bax_alu
    import bax_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Operation request, one per cycle when valid
    input  wire logic       req_valid,
    input  wire bax_req_t   req,
    // Register write-back
    output bax_wb_t         wb,
    // Architectural state
    output logic [7:0]      acc,
    output bax_flags_t      flags
);

    // One request is taken at each rising edge that sees req_valid high.
    // Every result is registered, so acc, flags and wb all move on that
    // edge and are seen one cycle later. The register operand is read by
    // the caller and handed over in the request; this block never reads
    // the register file itself, which keeps it a pure datapath stage.
    // Limitation: a register result leaves through wb one cycle late, so
    // a caller that issues back-to-back requests on the same register
    // must forward wb.data into the next operand itself.

    // Flags: the subtraction moves all three; both exclusive-OR forms move
    // only the zero flag; the nibble exchange moves none. The borrow flags
    // are stored as borrow-inverse, so they read as set when no borrow
    // occurred, the way a carry out of an addition would. Flags move even
    // when the result goes to the register, since they describe the
    // operation and not the destination.

    // The swap and the nibble borrow assume a byte of two nibbles
    if (BAX_DATA_W != 2 * BAX_NIB_W) begin : g_chk_nib
        $error("bax_alu: data width is not two nibbles");
    end
    // The address mask must span the whole address field
    if (BAX_ADDR_W != $bits(BAX_ADDR_MAX)) begin : g_chk_addr
        $error("bax_alu: address mask width mismatch");
    end

    // Selector decode
    logic        dest_is_reg;             // Selector asks for the register

    // Candidate results, all formed every cycle
    logic [7:0]  diff;                    // Subtractor result
    logic        borrow_n;                // Borrow inverse
    logic        half_borrow_n;           // Nibble borrow inverse
    logic [7:0]  lit_xor_res;             // Accumulator XOR literal
    logic [7:0]  reg_xor_res;             // Accumulator XOR operand
    logic [7:0]  swap_res;                // Operand with halves exchanged

    // Selected result and where it goes
    logic [7:0]  result;                  // Result of the taken operation
    logic        to_reg;                  // Result goes to the register
    logic        to_acc;                  // Result goes to the accumulator
    logic        upd_zero;                // Operation moves the zero flag
    logic        upd_borrow;              // Operation moves both borrow flags

    // Architectural state and its next values
    logic [7:0]  acc_reg, acc_next;       // Accumulator
    bax_flags_t  flags_reg, flags_next;   // Status flags
    bax_wb_t     wb_reg, wb_next;         // Registered write-back

    // Selector polarity is a package constant, not a bare literal
    assign dest_is_reg = (req.dest_reg == BAX_DEST_REG);

    // Register operand minus accumulator; the borrow outputs come out
    // inverted, which is exactly how the flags store them
    bax_sub #(
        .WIDTH         (BAX_DATA_W)
    ) i_bax_sub (
        .minuend       (req.operand),
        .subtrahend    (acc_reg),
        .difference    (diff),
        .borrow_n      (borrow_n),
        .half_borrow_n (half_borrow_n)
    );

    // The logic results read the registered accumulator, so a request in
    // the very next cycle already sees the value just written
    assign lit_xor_res = acc_reg ^ req.literal;                   // RULE_02
    assign reg_xor_res = acc_reg ^ req.operand;                   // RULE_03

    // Low nibble moves up, high nibble moves down
    assign swap_res    = {req.operand[BAX_NIB_W-1:0],
                          req.operand[BAX_DATA_W-1:BAX_NIB_W]};   // RULE_05

    // Result selection and routing for the taken operation
    always_comb begin
        // Defaults: no result, no destination, no flag moves
        result     = 8'h00;
        to_reg     = 1'b0;
        upd_zero   = 1'b0;
        upd_borrow = 1'b0;
        // Idle cycles select nothing, so acc and flags hold and wb clears
        if (req_valid) begin
            case (req.op)
                // Difference, with all three flags
                register_minus_accumulator_op: begin
                    result     = diff;                             // RULE_01
                    to_reg     = dest_is_reg;                      // RULE_01
                    upd_zero   = 1'b1;                             // RULE_07
                    upd_borrow = 1'b1;                             // RULE_07
                end
                // Literal form always lands in the accumulator
                literal_exclusive_or_op: begin
                    result     = lit_xor_res;                      // RULE_02
                    to_reg     = 1'b0;                             // RULE_02
                    upd_zero   = 1'b1;                             // RULE_07
                end
                // Register form, selectable destination
                register_exclusive_or_op: begin
                    result     = reg_xor_res;                      // RULE_03
                    to_reg     = dest_is_reg;                      // RULE_04
                    upd_zero   = 1'b1;                             // RULE_07
                end
                // Swap halves; flags deliberately left alone
                nibble_exchange_op: begin
                    result     = swap_res;                         // RULE_05
                    to_reg     = dest_is_reg;                      // RULE_06
                end
                // Unreachable with a two-bit code; kept so no latch forms
                default: begin
                    result     = 8'h00;
                    to_reg     = 1'b0;
                end
            endcase
        end
    end

    // Anything taken that is not bound for the register lands in acc
    assign to_acc = req_valid && !to_reg;

    // Accumulator next value: hold unless a result lands here
    always_comb begin
        // Hold by default
        acc_next = acc_reg;
        if (to_acc) begin
            // Selector zero, or the literal form
            acc_next = result;                                     // RULE_06
        end
    end

    // Accumulator register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Cleared with the core
            acc_reg <= BAX_ACC_RST;
        end else begin
            // Register the next value
            acc_reg <= acc_next;
        end
    end

    // Flag next value; an operation moves only the flags it names
    always_comb begin
        // Hold by default
        flags_next = flags_reg;
        if (upd_borrow) begin
            // Set when the accumulator does not exceed the operand
            flags_next.borrow_n_flag    = borrow_n;                // RULE_07
            flags_next.half_borrow_flag = half_borrow_n;           // RULE_07
        end
        if (upd_zero) begin
            // Judged on the result, whichever side it is written to
            flags_next.zero_flag = (result == 8'h00);              // RULE_07
        end
    end

    // Flag register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // All flags clear after reset
            flags_reg <= BAX_FLAG_RST;
        end else begin
            // Register the next value
            flags_reg <= flags_next;
        end
    end

    // Write-back next value: a one-cycle pulse per register result
    always_comb begin
        // Idle and accumulator cycles write nothing
        wb_next = '0;
        if (to_reg) begin
            // Mask keeps the address inside the 0 to 127 range
            wb_next.wr_en = 1'b1;                                  // RULE_04
            wb_next.addr  = req.addr & BAX_ADDR_MAX;               // RULE_03
            wb_next.data  = result;                                // RULE_01
        end
    end

    // Write-back register; clearing it each idle cycle makes the pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // No write may leave during reset
            wb_reg <= '0;
        end else begin
            // Register the next value
            wb_reg <= wb_next;
        end
    end

    // Outputs straight from flip-flops
    assign acc   = acc_reg;
    assign flags = flags_reg;
    assign wb    = wb_reg;

endmodule : bax_alu
`default_nettype wire

// file: src/bax_sub.sv
// Byte subtractor with borrow-inverse and half-borrow outputs
`timescale 1ns/100ps
`default_nettype none
module bax_sub
    import bax_pkg::*;
#(
    parameter int unsigned WIDTH = BAX_DATA_W
) (
    // Operands
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    // Results
    output logic      [WIDTH-1:0] difference,
    output logic                  borrow_n,
    output logic                  half_borrow_n
);

    // Nibble test needs at least two nibbles
    if (WIDTH < 2 * BAX_NIB_W) begin : g_chk
        $error("bax_sub: WIDTH too small");
    end

    logic [WIDTH:0]     full_diff;   // Extended difference
    logic [BAX_NIB_W:0] nib_diff;    // Low nibble difference

    // Two's complement subtraction; top bit set means a borrow
    always_comb begin
        full_diff     = {1'b0, minuend} - {1'b0, subtrahend};
        nib_diff      = {1'b0, minuend[BAX_NIB_W-1:0]}
                      - {1'b0, subtrahend[BAX_NIB_W-1:0]};
        difference    = full_diff[WIDTH-1:0];
        borrow_n      = ~full_diff[WIDTH];     // RULE_07
        half_borrow_n = ~nib_diff[BAX_NIB_W];  // RULE_07
    end

endmodule : bax_sub
`default_nettype wire

// file: verif/bax_alu_monitor.sv
// Checker for the byte ALU results and flags
`timescale 1ns/100ps
`default_nettype none
module bax_alu_monitor
    import bax_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Request and results
    input wire logic       req_valid,
    input wire bax_req_t   req,
    input wire bax_wb_t    wb,
    input wire logic [7:0] acc,
    input wire bax_flags_t flags
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Request kinds taken at this edge
    wire s_go = req_valid && req.op == register_minus_accumulator_op;
    wire l_go = req_valid && req.op == literal_exclusive_or_op;
    wire x_go = req_valid && req.op == register_exclusive_or_op;
    wire w_go = req_valid && req.op == nibble_exchange_op;
    chk_sub_acc: assert property (s_go && !req.dest_reg |=>
        acc == $past(req.operand) - $past(acc)) else $error("sub acc");
    chk_sub_flags: assert property (s_go |=>
        flags.borrow_n_flag == ($past(acc) <= $past(req.operand)) &&
        flags.half_borrow_flag == ($past(acc[3:0]) <= $past(req.operand[3:0])))
        else $error("sub flags");
    chk_lit_acc: assert property (l_go |=> !wb.wr_en &&
        acc == ($past(acc) ^ $past(req.literal))) else $error("lit xor");
    chk_xor_reg: assert property (x_go && req.dest_reg |=> wb.wr_en &&
        wb.data == ($past(acc) ^ $past(req.operand)) && $stable(acc))
        else $error("xor reg");
    chk_xor_acc: assert property (x_go && !req.dest_reg |=>
        acc == ($past(acc) ^ $past(req.operand)) &&
        flags.zero_flag == (acc == 8'h00)) else $error("xor acc");
    chk_swap_flags: assert property (w_go |=> $stable(flags))
        else $error("swap flags");
    chk_swap_acc: assert property (w_go && !req.dest_reg |=>
        acc == {$past(req.operand[3:0]), $past(req.operand[7:4])})
        else $error("swap acc");
    chk_sub_reg: assert property (s_go && req.dest_reg |=>
        wb.wr_en && wb.data == $past(req.operand) - $past(acc) &&
        $stable(acc)) else $error("sub reg");
    chk_sub_zero: assert property (s_go |=>
        flags.zero_flag == ($past(req.operand) == $past(acc)))
        else $error("sub zero");
    chk_lit_zero: assert property (l_go |=>
        flags.zero_flag == (($past(acc) ^ $past(req.literal)) == 8'h00))
        else $error("lit zero");
    chk_xor_keep: assert property (x_go || l_go |=>
        flags.borrow_n_flag == $past(flags.borrow_n_flag) &&
        flags.half_borrow_flag == $past(flags.half_borrow_flag))
        else $error("xor keeps borrows");
    chk_swap_reg: assert property (w_go && req.dest_reg |=>
        wb.wr_en && $stable(acc) &&
        wb.data == {$past(req.operand[3:0]), $past(req.operand[7:4])})
        else $error("swap reg");
    chk_idle_wb: assert property (!req_valid |=> !wb.wr_en)
        else $error("idle write");
endmodule : bax_alu_monitor
bind bax_alu bax_alu_monitor i_mon (.clk(clk), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .wb(wb), .acc(acc), .flags(flags));
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench for the byte ALU
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import bax_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       req_valid = 1'b0;
    bax_req_t   req = '0;
    bax_wb_t    wb;
    logic [7:0] acc;
    bax_flags_t flags;
    int         num_errors = 0;
    int         tests_run = 0;
    int         cycles = 0;
    bax_alu i_bax_alu (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
        .req(req), .wb(wb), .acc(acc), .flags(flags));
    // 100 ns clock
    initial forever #50 clk = ~clk;
    // One request from the next rising edge; results read at the falling
    // edge after it is taken, where they have settled
    task run(input bax_op_t o, input logic d, input logic [7:0] v, k);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{o, d, 7'h2A, v, k};
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
    endtask : run
    // Count and report one comparison
    task chk(input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH at %0t: check %0d wrong", $time, tests_run);
        end
    endtask : chk
    task test_done;
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Hang guard; the full run needs under 100 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            num_errors++;
            test_done();
        end
    end
    // Literal XOR, selector ignored
    task t_lit;
        run(literal_exclusive_or_op, 1'b1, 8'h00, 8'h3C);
        chk(acc === 8'h3C && wb.wr_en === 1'b0);
        run(literal_exclusive_or_op, 1'b0, 8'h00, 8'h3C);
        chk(acc === 8'h00 && flags.zero_flag === 1'b1);
    endtask : t_lit
    // Subtract into register, into acc, then with borrow
    task t_sub;
        run(literal_exclusive_or_op, 1'b0, 8'h00, 8'h03);
        run(register_minus_accumulator_op, 1'b1, 8'h05, 8'h00);
        chk(wb === {1'b1, 7'h2A, 8'h02} && acc === 8'h03);
        chk(flags === 3'h3);
        run(register_minus_accumulator_op, 1'b0, 8'h03, 8'h00);
        chk(acc === 8'h00 && flags === 3'h7);
        run(literal_exclusive_or_op, 1'b0, 8'h00, 8'h10);
        run(register_minus_accumulator_op, 1'b0, 8'h05, 8'h00);
        chk(acc === 8'hF5 && flags === 3'h2);
    endtask : t_sub
    // Register XOR both ways
    task t_xor;
        run(register_exclusive_or_op, 1'b1, 8'h0F, 8'h00);
        chk(wb === {1'b1, 7'h2A, 8'hFA} && acc === 8'hF5);
        run(register_exclusive_or_op, 1'b0, 8'hF5, 8'h00);
        chk(acc === 8'h00 && flags === 3'h6);
    endtask : t_xor
    // Nibble exchange both ways
    task t_swap;
        run(nibble_exchange_op, 1'b0, 8'hA5, 8'h00);
        chk(acc === 8'h5A && flags === 3'h6);
        run(nibble_exchange_op, 1'b1, 8'h3C, 8'h00);
        chk(wb.data === 8'hC3 && acc === 8'h5A && flags === 3'h6);
        chk(wb.wr_en === 1'b1 && wb.addr === 7'h2A);
    endtask : t_swap
    // Back-to-back requests: the subtraction must see the new accumulator
    task t_b2b;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{literal_exclusive_or_op, 1'b0, 7'h2A, 8'h00, 8'h5A};
        @(posedge clk);
        req <= '{register_minus_accumulator_op, 1'b0, 7'h2A, 8'h5A, 8'h00};
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        chk(acc === 8'h5A && flags === 3'h3 && wb.wr_en === 1'b0);
    endtask : t_b2b
    // Reset in mid-run, then a first request straight after release
    task t_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        @(negedge clk);
        chk(acc === 8'h00 && flags === 3'h0 && wb.wr_en === 1'b0);
        @(posedge clk);
        reset_n <= 1'b1;
        run(literal_exclusive_or_op, 1'b0, 8'h00, 8'h81);
        chk(acc === 8'h81 && flags === 3'h0);
    endtask : t_reset
    initial begin
        repeat (15) @(posedge clk);
        @(negedge clk);
        chk(acc === 8'h00 && flags === 3'h0 && wb.wr_en === 1'b0);
        @(posedge clk);
        reset_n <= 1'b1;
        t_lit();
        t_sub();
        t_xor();
        t_swap();
        t_b2b();
        t_reset();
        test_done();
    end
endmodule : testbench
`default_nettype wire
